/* File: common/acmp_cfg.svh */
// Purpose: Addresses, field positions and reset values of the comparator configuration registers.
// Assumes: Byte-wide special function register space with 8-bit addresses.
// Notes: Definitions only.
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH

`define ACMP_ADDR_CTRL1 8'h9A
`define ACMP_ADDR_MODE1 8'h9C
`define ACMP_ADDR_MUX1 8'h9E
`define ACMP_ADDR_MUX0 8'h9F

`define ACMP_CTRL1_OUT_BIT 6
`define ACMP_CTRL1_RISE_BIT 5
`define ACMP_CTRL1_FALL_BIT 4

`define ACMP_MODE1_RISE_EN_BIT 5
`define ACMP_MODE1_FALL_EN_BIT 4
`define ACMP_MODE1_RESP_HI 1
`define ACMP_MODE1_RESP_LO 0

`define ACMP_MUX_NEG_HI 5
`define ACMP_MUX_NEG_LO 4
`define ACMP_MUX_POS_HI 1
`define ACMP_MUX_POS_LO 0

`define ACMP_MODE1_RESET 8'h02
`define ACMP_RESP_RESET 2'h2
`define ACMP_ROUTE_RESET 2'h0
`define ACMP_READ_UNMAPPED 8'h00

`define ACMP_SYNC_PRIME_CYCLES 2'h3

`endif

/* File: common/acmp_pkg.sv */
// Purpose: Types shared by the comparator configuration register logic.
// Assumes: Nothing beyond the configuration header.
// Notes: Mode codes follow declaration order, fastest first.
package acmp_pkg;

  typedef enum logic [1:0] {
    ACMP_RESP_FASTEST,
    ACMP_RESP_MID_FAST,
    ACMP_RESP_MID_SLOW,
    ACMP_RESP_SLOWEST
  } acmp_resp_mode_e;

  typedef logic [1:0] acmp_route_t;

endpackage

/* File: rtl/acmp_config_regs.sv */
// Purpose: Configuration registers for two analog comparators on the special function register port.
// Assumes: One access per cycle; read data appear the cycle after the read strobe.
// Notes: Unused bits read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_cfg.svh"

module acmp_config_regs (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic cmp1_async_i,
  output logic cmp1_rise_irq_enable_o,
  output logic cmp1_fall_irq_enable_o,
  output acmp_pkg::acmp_resp_mode_e cmp1_response_mode_o,
  output acmp_pkg::acmp_route_t cmp0_negative_route_o,
  output acmp_pkg::acmp_route_t cmp0_positive_route_o,
  output acmp_pkg::acmp_route_t cmp1_negative_route_o,
  output acmp_pkg::acmp_route_t cmp1_positive_route_o,
  output logic cmp1_irq_o
);

  logic wr_ctrl1;
  logic wr_mode1;
  logic wr_mux1;
  logic wr_mux0;
  logic cmp1_output_state;
  logic cmp1_rise_flag;
  logic cmp1_fall_flag;
  logic clr_rise;
  logic clr_fall;
  logic irq_nxt;
  logic [7:0] rdata_nxt;

  assign wr_ctrl1 = sfr_wr_i && (sfr_addr_i == `ACMP_ADDR_CTRL1);
  assign wr_mode1 = sfr_wr_i && (sfr_addr_i == `ACMP_ADDR_MODE1);
  assign wr_mux1 = sfr_wr_i && (sfr_addr_i == `ACMP_ADDR_MUX1);
  assign wr_mux0 = sfr_wr_i && (sfr_addr_i == `ACMP_ADDR_MUX0);

  // Writing a zero to a flag bit clears it; writing a one leaves it alone.
  assign clr_rise = wr_ctrl1 && !sfr_wdata_i[`ACMP_CTRL1_RISE_BIT];
  assign clr_fall = wr_ctrl1 && !sfr_wdata_i[`ACMP_CTRL1_FALL_BIT];

  acmp_edge_flags u_edge_flags (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .cmp_async_i(cmp1_async_i),
    .clr_rise_i(clr_rise),
    .clr_fall_i(clr_fall),
    .state_o(cmp1_output_state),
    .rise_flag_o(cmp1_rise_flag),
    .fall_flag_o(cmp1_fall_flag)
  );

  // Only the defined fields are stored, so unused bits cannot take a written value.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp1_rise_irq_enable_o <= 1'b0;
      cmp1_fall_irq_enable_o <= 1'b0;
      cmp1_response_mode_o <= acmp_pkg::acmp_resp_mode_e'(`ACMP_RESP_RESET);
    end else if (wr_mode1) begin
      cmp1_rise_irq_enable_o <= sfr_wdata_i[`ACMP_MODE1_RISE_EN_BIT];
      cmp1_fall_irq_enable_o <= sfr_wdata_i[`ACMP_MODE1_FALL_EN_BIT];
      cmp1_response_mode_o <=
        acmp_pkg::acmp_resp_mode_e'(sfr_wdata_i[`ACMP_MODE1_RESP_HI:`ACMP_MODE1_RESP_LO]);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp0_negative_route_o <= `ACMP_ROUTE_RESET;
      cmp0_positive_route_o <= `ACMP_ROUTE_RESET;
    end else if (wr_mux0) begin
      cmp0_negative_route_o <= sfr_wdata_i[`ACMP_MUX_NEG_HI:`ACMP_MUX_NEG_LO];
      cmp0_positive_route_o <= sfr_wdata_i[`ACMP_MUX_POS_HI:`ACMP_MUX_POS_LO];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp1_negative_route_o <= `ACMP_ROUTE_RESET;
      cmp1_positive_route_o <= `ACMP_ROUTE_RESET;
    end else if (wr_mux1) begin
      cmp1_negative_route_o <= sfr_wdata_i[`ACMP_MUX_NEG_HI:`ACMP_MUX_NEG_LO];
      cmp1_positive_route_o <= sfr_wdata_i[`ACMP_MUX_POS_HI:`ACMP_MUX_POS_LO];
    end
  end

  // Read view; bits that are not fields stay zero.
  always_comb begin
    rdata_nxt = `ACMP_READ_UNMAPPED;
    unique case (sfr_addr_i)
      `ACMP_ADDR_CTRL1: begin
        rdata_nxt[`ACMP_CTRL1_OUT_BIT] = cmp1_output_state;
        rdata_nxt[`ACMP_CTRL1_RISE_BIT] = cmp1_rise_flag;
        rdata_nxt[`ACMP_CTRL1_FALL_BIT] = cmp1_fall_flag;
      end
      `ACMP_ADDR_MODE1: begin
        rdata_nxt[`ACMP_MODE1_RISE_EN_BIT] = cmp1_rise_irq_enable_o;
        rdata_nxt[`ACMP_MODE1_FALL_EN_BIT] = cmp1_fall_irq_enable_o;
        rdata_nxt[`ACMP_MODE1_RESP_HI:`ACMP_MODE1_RESP_LO] = cmp1_response_mode_o;
      end
      `ACMP_ADDR_MUX1: begin
        rdata_nxt[`ACMP_MUX_NEG_HI:`ACMP_MUX_NEG_LO] = cmp1_negative_route_o;
        rdata_nxt[`ACMP_MUX_POS_HI:`ACMP_MUX_POS_LO] = cmp1_positive_route_o;
      end
      `ACMP_ADDR_MUX0: begin
        rdata_nxt[`ACMP_MUX_NEG_HI:`ACMP_MUX_NEG_LO] = cmp0_negative_route_o;
        rdata_nxt[`ACMP_MUX_POS_HI:`ACMP_MUX_POS_LO] = cmp0_positive_route_o;
      end
      default: begin
        rdata_nxt = `ACMP_READ_UNMAPPED;
      end
    endcase
  end

  // Read data hold until the next read strobe.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= `ACMP_READ_UNMAPPED;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rdata_nxt;
    end
  end

  assign irq_nxt = (cmp1_rise_flag && cmp1_rise_irq_enable_o) ||
                   (cmp1_fall_flag && cmp1_fall_irq_enable_o);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp1_irq_o <= 1'b0;
    end else begin
      cmp1_irq_o <= irq_nxt;
    end
  end

  logic after_reset_r;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      after_reset_r <= 1'b1;
    end else begin
      after_reset_r <= 1'b0;
    end
  end

  chk_mode_unused_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == `ACMP_ADDR_MODE1 |=> sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3:2] == 2'h0)
    else $error("mode register unused bits read nonzero");

  chk_rise_en_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mode1 |=> cmp1_rise_irq_enable_o == $past(sfr_wdata_i[5]))
    else $error("rise enable did not take written bit 5");

  chk_fall_en_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mode1 ##1 !wr_mode1 ##1 sfr_rd_i && sfr_addr_i == `ACMP_ADDR_MODE1 && !wr_mode1 |=>
    sfr_rdata_o[4] == $past(sfr_wdata_i[4], 3))
    else $error("fall enable readback does not match write");

  chk_mode_reset_value: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    after_reset_r |-> cmp1_response_mode_o == acmp_pkg::ACMP_RESP_MID_SLOW && !cmp1_rise_irq_enable_o &&
    !cmp1_fall_irq_enable_o)
    else $error("mode register reset value wrong");

  chk_cmp0_neg_route: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mux0 |=> cmp0_negative_route_o == $past(sfr_wdata_i[5:4]))
    else $error("comparator 0 negative route not written");

  chk_cmp0_pos_route: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mux0 |=> $stable(cmp0_positive_route_o))
    else $error("comparator 0 positive route changed without a write");

  chk_cmp1_neg_route: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mux1 |=> cmp1_negative_route_o == $past(sfr_wdata_i[5:4]))
    else $error("comparator 1 negative route not written");

  chk_cmp1_pos_route: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mux1 |=> cmp1_positive_route_o == $past(sfr_wdata_i[1:0]))
    else $error("comparator 1 positive route not written");

  chk_mux_unused_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    sfr_rd_i && (sfr_addr_i == `ACMP_ADDR_MUX0 || sfr_addr_i == `ACMP_ADDR_MUX1) |=>
    sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3:2] == 2'h0)
    else $error("input select unused bits read nonzero");

  chk_flag_clear_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clr_rise |=> !cmp1_rise_flag || $rose(cmp1_output_state))
    else $error("rise flag survived a clear without an edge");

  chk_irq_request: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cmp1_rise_flag && cmp1_rise_irq_enable_o ##1 cmp1_rise_flag && cmp1_rise_irq_enable_o |-> cmp1_irq_o)
    else $error("interrupt request missing with flag and enable set");

  chk_irq_quiet: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !cmp1_rise_irq_enable_o && !cmp1_fall_irq_enable_o ##1 !cmp1_rise_irq_enable_o && !cmp1_fall_irq_enable_o
    |-> !cmp1_irq_o)
    else $error("interrupt request with both enables off");

  // Every mode and input select field must keep its value between writes and read back exactly as stored.
  chk_resp_mode_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mode1 |=> cmp1_response_mode_o == $past(sfr_wdata_i[1:0]))
    else $error("response mode did not take written bits 1:0");

  chk_fall_en_direct: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mode1 |=> cmp1_fall_irq_enable_o == $past(sfr_wdata_i[4]))
    else $error("fall enable did not take written bit 4");

  chk_cmp0_pos_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mux0 |=> cmp0_positive_route_o == $past(sfr_wdata_i[1:0]))
    else $error("comparator 0 positive route not written");

  chk_cmp0_neg_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mux0 |=> $stable(cmp0_negative_route_o))
    else $error("comparator 0 negative route changed without a write");

  chk_cmp1_neg_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mux1 |=> $stable(cmp1_negative_route_o))
    else $error("comparator 1 negative route changed without a write");

  chk_cmp1_pos_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mux1 |=> $stable(cmp1_positive_route_o))
    else $error("comparator 1 positive route changed without a write");

  chk_rise_en_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mode1 |=> $stable(cmp1_rise_irq_enable_o))
    else $error("rise enable changed without a write");

  chk_fall_en_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mode1 |=> $stable(cmp1_fall_irq_enable_o))
    else $error("fall enable changed without a write");

  chk_resp_mode_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !wr_mode1 |=> $stable(cmp1_response_mode_o))
    else $error("response mode changed without a write");

  chk_mux_reset_value: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    after_reset_r |-> cmp0_negative_route_o == 2'h0 && cmp0_positive_route_o == 2'h0 &&
    cmp1_negative_route_o == 2'h0 && cmp1_positive_route_o == 2'h0)
    else $error("input select reset value wrong");

  chk_mode_read_fields: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == `ACMP_ADDR_MODE1 |=> sfr_rdata_o[5] == $past(cmp1_rise_irq_enable_o) &&
    sfr_rdata_o[4] == $past(cmp1_fall_irq_enable_o) && sfr_rdata_o[1:0] == $past(cmp1_response_mode_o))
    else $error("mode register readback does not match its fields");

  chk_mux0_read_fields: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == `ACMP_ADDR_MUX0 |=> sfr_rdata_o[5:4] == $past(cmp0_negative_route_o) &&
    sfr_rdata_o[1:0] == $past(cmp0_positive_route_o))
    else $error("comparator 0 input select readback wrong");

  chk_mux1_read_fields: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == `ACMP_ADDR_MUX1 |=> sfr_rdata_o[5:4] == $past(cmp1_negative_route_o) &&
    sfr_rdata_o[1:0] == $past(cmp1_positive_route_o))
    else $error("comparator 1 input select readback wrong");

  chk_ctrl_read_fields: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == `ACMP_ADDR_CTRL1 |=> sfr_rdata_o[6] == $past(cmp1_output_state) &&
    sfr_rdata_o[5] == $past(cmp1_rise_flag) && sfr_rdata_o[4] == $past(cmp1_fall_flag) &&
    sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[3:0] == 4'h0)
    else $error("control register readback wrong");

  chk_rise_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cmp1_rise_flag && !clr_rise |=> cmp1_rise_flag)
    else $error("rising flag dropped without a clear");

  chk_fall_flag_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clr_fall |=> !cmp1_fall_flag || $fell(cmp1_output_state))
    else $error("fall flag survived a clear without an edge");

  chk_fall_irq_request: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cmp1_fall_flag && cmp1_fall_irq_enable_o ##1 cmp1_fall_flag && cmp1_fall_irq_enable_o |-> cmp1_irq_o)
    else $error("interrupt request missing with fall flag and enable set");

  chk_irq_no_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !cmp1_rise_flag && !cmp1_fall_flag ##1 !cmp1_rise_flag && !cmp1_fall_flag |-> !cmp1_irq_o)
    else $error("interrupt request with no flag set");

  chk_rise_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !cmp1_rise_irq_enable_o && !cmp1_fall_flag ##1 !cmp1_rise_irq_enable_o && !cmp1_fall_flag |-> !cmp1_irq_o)
    else $error("rising flag raised a request while disabled");

  chk_fall_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !cmp1_fall_irq_enable_o && !cmp1_rise_flag ##1 !cmp1_fall_irq_enable_o && !cmp1_rise_flag |-> !cmp1_irq_o)
    else $error("falling flag raised a request while disabled");

endmodule
`default_nettype wire

/* File: rtl/acmp_edge_flags.sv */
// Purpose: Synchronises the comparator-1 output and keeps its sticky edge flags.
// Assumes: The comparator output is asynchronous to core_clk_i.
// Notes: Edges are only detected once the synchroniser holds a real sample.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_cfg.svh"

module acmp_edge_flags (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cmp_async_i,
  input wire logic clr_rise_i,
  input wire logic clr_fall_i,
  output logic state_o,
  output logic rise_flag_o,
  output logic fall_flag_o
);

  logic sync1_r;
  logic sync2_r;
  logic [1:0] prime_r;
  logic primed;
  logic rise_evt;
  logic fall_evt;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= cmp_async_i;
      sync2_r <= sync1_r;
    end
  end

  // Holds edge detection off until both synchroniser stages and the previous sample carry real values.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prime_r <= 2'h0;
    end else if (prime_r != `ACMP_SYNC_PRIME_CYCLES) begin
      prime_r <= prime_r + 2'h1;
    end
  end

  assign primed = (prime_r == `ACMP_SYNC_PRIME_CYCLES);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_o <= 1'b0;
    end else begin
      state_o <= sync2_r;
    end
  end

  assign rise_evt = primed && sync2_r && !state_o;
  assign fall_evt = primed && !sync2_r && state_o;

  // A new edge wins over a clear in the same cycle.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_flag_o <= 1'b0;
    end else if (rise_evt) begin
      rise_flag_o <= 1'b1;
    end else if (clr_rise_i) begin
      rise_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fall_flag_o <= 1'b0;
    end else if (fall_evt) begin
      fall_flag_o <= 1'b1;
    end else if (clr_fall_i) begin
      fall_flag_o <= 1'b0;
    end
  end

  chk_rise_sets_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rise_evt |=> rise_flag_o) else $error("rising edge did not set its flag");

  chk_fall_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    fall_flag_o && !clr_fall_i |=> fall_flag_o) else $error("falling flag dropped without a clear");

endmodule
`default_nettype wire

/* File: verif/acmp_cmp_model.sv */
// Purpose: Behavioural comparator-1 core feeding the register block.
// Assumes: The analog decision settles a few ns after the inputs move.
// Notes: Output is unrelated in phase to the core clock.
`timescale 1ns/1ps
`default_nettype none

module acmp_cmp_model (
  input wire logic level_i,
  output logic cmp_o
);
  initial cmp_o = 1'b0;
  // The delay keeps output changes away from the clock edge.
  always @(level_i) begin
    cmp_o <= #3 level_i;
  end
endmodule

`default_nettype wire

/* File: verif/acmp_config_regs_tb.sv */
// Purpose: Self-checking bench for the comparator configuration registers.
// Assumes: Register port and edge timing as handed over.
// Notes: Flags are read and cleared at the control address.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_cfg.svh"

module acmp_config_regs_tb;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic lvl = 1'b0;
  logic cmp1;
  logic ren;
  logic fen;
  logic irq;
  acmp_pkg::acmp_resp_mode_e mode;
  acmp_pkg::acmp_route_t n0, p0, n1, p1;
  int miscompares = 0;
  int checked = 0;
  logic [1:0] c;

  always #4 core_clk_i = ~core_clk_i;

  acmp_config_regs uut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .cmp1_async_i(cmp1),
    .cmp1_rise_irq_enable_o(ren), .cmp1_fall_irq_enable_o(fen),
    .cmp1_response_mode_o(mode), .cmp0_negative_route_o(n0),
    .cmp0_positive_route_o(p0), .cmp1_negative_route_o(n1),
    .cmp1_positive_route_o(p1), .cmp1_irq_o(irq)
  );

  acmp_cmp_model cmp_model (
    .level_i(lvl),
    .cmp_o(cmp1)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    chk(sfr_rdata_o, exp);
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 10) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  task automatic mode_chk(input logic [7:0] exp);
    chk({2'h0, ren, fen, 2'h0, mode}, exp);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (9) @(posedge core_clk_i);
    #1;
    mode_chk(8'h02);
    chk({n0, p0, n1, p1}, 8'h00);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rdchk(`ACMP_ADDR_MODE1, 8'h02);
    rdchk(`ACMP_ADDR_MUX1, 8'h00);
    rdchk(`ACMP_ADDR_MUX0, 8'h00);
    rdchk(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(`ACMP_ADDR_MODE1, {2'b11, c, 2'b11, c});
      mode_chk({2'b00, c, 2'b00, c});
      rdchk(`ACMP_ADDR_MODE1, {2'b00, c, 2'b00, c});
      wr(`ACMP_ADDR_MUX0, {2'b11, ~c, 2'b11, c});
      wr(`ACMP_ADDR_MUX1, {2'b11, c, 2'b11, ~c});
      chk({n0, p0, n1, p1}, {~c, c, c, ~c});
      rdchk(`ACMP_ADDR_MUX0, {2'b00, ~c, 2'b00, c});
      rdchk(`ACMP_ADDR_MUX1, {2'b00, c, 2'b00, ~c});
    end
    wr(`ACMP_ADDR_MODE1, 8'h20);
    wr(`ACMP_ADDR_CTRL1, 8'h00);
    wait_irq(1'b0);
    lvl = 1'b1;
    wait_irq(1'b1);
    rdchk(`ACMP_ADDR_CTRL1, 8'h60);
    lvl = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rdchk(`ACMP_ADDR_CTRL1, 8'h30);
    wr(`ACMP_ADDR_CTRL1, 8'h10);
    wait_irq(1'b0);
    wr(`ACMP_ADDR_MODE1, 8'h10);
    wait_irq(1'b1);
    wr(`ACMP_ADDR_CTRL1, 8'h20);
    wait_irq(1'b0);
    rdchk(`ACMP_ADDR_CTRL1, 8'h00);
    lvl = 1'b1;
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (9) @(posedge core_clk_i);
    #1;
    mode_chk(8'h02);
    chk({n0, p0, n1, p1}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rdchk(`ACMP_ADDR_CTRL1, 8'h40);
    rdchk(`ACMP_ADDR_MODE1, 8'h02);
    wait_irq(1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
